//--- ssw_cfg.svh
`ifndef SSW_CFG_SVH
`define SSW_CFG_SVH

// Clock rate and derived periods
`define SSW_CLK_HZ          40000000
`define SSW_RESET_MS        200
`define SSW_WDOG_MS         1600
`define SSW_RESET_CYCLES    ((`SSW_CLK_HZ / 1000) * `SSW_RESET_MS)
`define SSW_WDOG_CYCLES     ((`SSW_CLK_HZ / 1000) * `SSW_WDOG_MS)
`define SSW_DEBOUNCE_NS     1000
`define SSW_DEBOUNCE_CYCLES ((`SSW_DEBOUNCE_NS * (`SSW_CLK_HZ / 1000000) + 999) / 1000)
`define SSW_CNT_W           32
`define SSW_DB_W            8

`endif

//--- ssw_debounce.sv
`timescale 1ns/1ps
`include "ssw_cfg.svh"
module ssw_debounce
    import ssw_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic raw_in,
    output logic      clean_q
);
    logic [`SSW_DB_W-1:0] cnt_q;

    // Output follows input only after it is steady for the full window
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q   <= '0;
            clean_q <= 1'b1;
        end else if (raw_in == clean_q) begin
            cnt_q <= '0;
        end else if (cnt_q == `SSW_DB_W'(`SSW_DEBOUNCE_CYCLES - 1)) begin
            cnt_q   <= '0;
            clean_q <= raw_in;
        end else begin
            cnt_q <= cnt_q + `SSW_DB_W'(1);
        end
    end
endmodule

//--- ssw_host_model.sv
`timescale 1ns/1ps
module ssw_host_model #(
    parameter int KICK_GAP = 20
) (
    input  wire logic       ref_clk,
    input  wire logic [1:0] mode,
    output logic            watchdog_kick_in,
    output logic            watchdog_kick_hiz
);
    int gap_q = 0;
    initial watchdog_kick_in = 1'b0;
    initial watchdog_kick_hiz = 1'b0;
    always @(posedge ref_clk) begin
        watchdog_kick_hiz <= (mode == 2'h2);
        gap_q <= (gap_q + 1) % KICK_GAP;
        if (mode == 2'h0 && gap_q == 0)
            watchdog_kick_in <= ~watchdog_kick_in;
        // Released line shows inverse level
        else if (mode == 2'h2 && !watchdog_kick_hiz)
            watchdog_kick_in <= ~watchdog_kick_in;
    end
endmodule

//--- ssw_pkg.sv
package ssw_pkg;
    typedef enum logic [1:0] {
        SSW_RST_IDLE  = 2'b00,
        SSW_RST_HOLD  = 2'b01,
        SSW_RST_PULSE = 2'b10
    } ssw_rst_state_type;

    typedef logic [31:0] ssw_count_type;
endpackage

//--- ssw_supervisor.sv
// Summary of operation
// [R1] Any reset source gives 200 ms low reset
// [R2] Reset held low throughout low-line
// [R3] 200 ms more after low-line or manual release
// [R4] Manual reset input is active low
// [R5] Manual reset debounced to single event
// [R6] Static kick for 1.6 s expires watchdog
// [R7] Timeout output low until timer cleared
// [R8] Asserted reset clears the watchdog timer
// [R9] Kick edges or high-Z clear watchdog
// [R10] Floating kick input disables the watchdog
// [R11] Timeout output low during low-line
// [R12] Timeout releases immediately when low-line ends
// [R13] Watchdog timeout never asserts reset internally
// [R14] Power-fail flag low when sense high
// [R15] Watchdog independent, omittable by build option
// [R16] Active-high reset is exact complement
// [R17] Durations counted from clock cycles, parameterised
`timescale 1ns/1ps
`include "ssw_cfg.svh"
module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter ssw_count_type RESET_CYCLES = `SSW_RESET_CYCLES,
    parameter ssw_count_type WDOG_CYCLES  = `SSW_WDOG_CYCLES,
    parameter bit            WDOG_ENABLE  = 1'b1
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic low_line,
    input  wire logic manual_reset_n,
    input  wire logic power_fail_sense_in,
    input  wire logic watchdog_kick_in,
    input  wire logic watchdog_kick_hiz,
    output logic      reset_out_n_q,
    output logic      reset_out_q,
    output logic      watchdog_timeout_n_q,
    output logic      power_fail_flag_n_q
);
    ssw_rst_state_type state_q;
    ssw_count_type     pulse_cnt_q;
    logic              mr_clean;
    logic              mr_prev_q;
    logic              kick_prev_q;
    logic              wd_expired;
    logic              wd_clear;
    logic              mr_fall;
    ssw_count_type     rel_run_q;
    ssw_count_type     quiet_q;
    ssw_count_type     mr_low_run_q;
    ssw_count_type     mr_high_run_q;

    // Reset may be released only from idle with both causes gone
    function automatic logic release_ok(
        input ssw_rst_state_type st,
        input logic              low,
        input logic              mr
    );
        return (st == SSW_RST_IDLE) && !low && mr;
    endfunction

    // [R5] debounce manual reset
    ssw_debounce u_debounce (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .raw_in  (manual_reset_n),
        .clean_q (mr_clean)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mr_prev_q   <= 1'b1;
            kick_prev_q <= 1'b0;
        end else begin
            mr_prev_q   <= mr_clean;
            kick_prev_q <= watchdog_kick_in;
        end
    end

    // [R4] active-low trigger
    assign mr_fall = mr_prev_q && !mr_clean;

    // [R1] [R2] [R3] reset pulse machine
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q     <= SSW_RST_HOLD;
            pulse_cnt_q <= '0;
        end else begin
            case (state_q)
                SSW_RST_IDLE: begin
                    pulse_cnt_q <= '0;
                    // [R4] debounced falling edge starts reset
                    if (low_line || mr_fall) begin
                        state_q <= SSW_RST_HOLD;
                    end
                end
                SSW_RST_HOLD: begin
                    pulse_cnt_q <= '0;
                    if (!low_line && mr_clean) begin
                        state_q <= SSW_RST_PULSE;
                    end
                end
                SSW_RST_PULSE: begin
                    if (low_line || !mr_clean) begin
                        state_q     <= SSW_RST_HOLD;
                        pulse_cnt_q <= '0;
                    end else if (pulse_cnt_q == RESET_CYCLES - 32'd1) begin
                        state_q     <= SSW_RST_IDLE;
                        pulse_cnt_q <= '0;
                    end else begin
                        pulse_cnt_q <= pulse_cnt_q + 32'd1;
                    end
                end
                default: begin
                    state_q     <= SSW_RST_HOLD;
                    pulse_cnt_q <= '0;
                end
            endcase
        end
    end

    // [R13] watchdog never feeds reset; [R16] complement output
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reset_out_n_q <= 1'b0;
            reset_out_q   <= 1'b1;
        end else begin
            reset_out_n_q <= release_ok(state_q, low_line, mr_clean);
            reset_out_q   <= !release_ok(state_q, low_line, mr_clean);
        end
    end

    // [R8] [R9] [R10] watchdog clear sources
    assign wd_clear = !reset_out_n_q || watchdog_kick_hiz || (watchdog_kick_in != kick_prev_q);

    generate
        if (WDOG_ENABLE) begin : g_wdog
            // [R6] [R17] watchdog timer
            ssw_watchdog #(
                .WDOG_CYCLES (WDOG_CYCLES)
            ) u_watchdog (
                .ref_clk   (ref_clk),
                .rst_n     (rst_n),
                .clear     (wd_clear),
                .expired_q (wd_expired)
            );
        end else begin : g_no_wdog
            // [R15] watchdog omitted
            assign wd_expired = 1'b0;
        end
    endgenerate

    // [R7] [R11] [R12] timeout output
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            watchdog_timeout_n_q <= 1'b1;
        end else begin
            watchdog_timeout_n_q <= !(low_line || wd_expired);
        end
    end

    // [R14] power-fail flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            power_fail_flag_n_q <= 1'b1;
        end else begin
            power_fail_flag_n_q <= !power_fail_sense_in;
        end
    end

    // Assertions
    a_reset_complement: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
        reset_out_q == !reset_out_n_q)
        else $error("active-high reset not complement");

    a_lowline_holds_reset: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
        low_line |=> !reset_out_n_q)
        else $error("reset released during low-line");

    a_lowline_wdo_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
        low_line |=> !watchdog_timeout_n_q)
        else $error("timeout not low during low-line");

    a_wdo_fast_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
        (!low_line && !wd_expired) |=> watchdog_timeout_n_q)
        else $error("timeout output not released");

    a_pfo_follows: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
        power_fail_sense_in |=> !power_fail_flag_n_q)
        else $error("power-fail flag not low");

    a_pulse_min: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
        (state_q == SSW_RST_HOLD) ##1 (state_q == SSW_RST_PULSE) |-> !reset_out_n_q [*8])
        else $error("reset pulse too short");

    a_wd_clear_on_reset: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
        !reset_out_n_q |=> !wd_expired)
        else $error("watchdog not cleared by reset");

    a_kick_edge_clears: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
        (watchdog_kick_in != kick_prev_q) |=> !wd_expired)
        else $error("kick edge did not clear watchdog");

    a_hiz_disables: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
        watchdog_kick_hiz |=> !wd_expired)
        else $error("floating kick did not disable watchdog");

    a_mr_holds_reset: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
        !mr_clean |=> !reset_out_n_q)
        else $error("reset released while manual reset low");

    // Assertion helpers
    // Cycles of held reset since both causes cleared
    always_ff @(posedge ref_clk) begin
        if (!rst_n || low_line || !mr_clean) begin
            rel_run_q <= '0;
        end else if (!reset_out_n_q) begin
            rel_run_q <= rel_run_q + 32'd1;
        end
    end

    // Cycles since the watchdog was last cleared
    // Saturates so a long quiet spell never wraps
    always_ff @(posedge ref_clk) begin
        if (!rst_n || wd_clear) begin
            quiet_q <= '0;
        end else if (quiet_q != '1) begin
            quiet_q <= quiet_q + 32'd1;
        end
    end

    // Consecutive cycles the raw manual input sat low
    always_ff @(posedge ref_clk) begin
        if (!rst_n || manual_reset_n) begin
            mr_low_run_q <= '0;
        end else if (mr_low_run_q != '1) begin
            mr_low_run_q <= mr_low_run_q + 32'd1;
        end
    end

    // Consecutive cycles the raw manual input sat high
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !manual_reset_n) begin
            mr_high_run_q <= '0;
        end else if (mr_high_run_q != '1) begin
            mr_high_run_q <= mr_high_run_q + 32'd1;
        end
    end

    a_release_span: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
        $rose(reset_out_n_q) |-> (rel_run_q >= RESET_CYCLES) && (rel_run_q <= RESET_CYCLES + 32'd2))
        else $error("reset pulse length out of range");

    a_wdog_not_early: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
        (quiet_q >= 32'd1 && quiet_q <= WDOG_CYCLES && !$past(low_line)) |-> watchdog_timeout_n_q)
        else $error("watchdog expired too early");

    a_wdog_not_late: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
        (WDOG_ENABLE && quiet_q > WDOG_CYCLES) |-> !watchdog_timeout_n_q)
        else $error("watchdog did not expire");

    a_expiry_sticks: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
        (wd_expired && !wd_clear) |=> wd_expired)
        else $error("expiry dropped without clear");

    a_expiry_drives_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
        wd_expired |=> !watchdog_timeout_n_q)
        else $error("expiry not shown on timeout output");

    a_wdog_no_reset: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
        (wd_expired && !low_line && mr_clean && state_q == SSW_RST_IDLE) |=> reset_out_n_q)
        else $error("watchdog expiry pulled reset");

    a_pfo_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
        !power_fail_sense_in |=> power_fail_flag_n_q)
        else $error("power-fail flag not high");

    a_mr_fall_resets: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
        mr_fall |=> !reset_out_n_q)
        else $error("manual reset edge did not reset");

    a_mr_settled_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
        $fell(mr_clean) |-> mr_low_run_q >= `SSW_DEBOUNCE_CYCLES)
        else $error("manual reset taken before settling low");

    a_mr_settled_high: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
        $rose(mr_clean) |-> mr_high_run_q >= `SSW_DEBOUNCE_CYCLES)
        else $error("manual release taken before settling high");

    a_lowline_hold_state: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
        low_line |=> state_q == SSW_RST_HOLD)
        else $error("low-line did not hold reset machine");

    a_hiz_keeps_high: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
        watchdog_kick_hiz ##1 watchdog_kick_hiz |=> (watchdog_timeout_n_q || $past(low_line)))
        else $error("floating kick let timeout assert");

    a_lowline_end_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
        ($fell(low_line) && !wd_expired) |=> watchdog_timeout_n_q)
        else $error("timeout output delayed after low-line");
endmodule

//--- ssw_watchdog.sv
`timescale 1ns/1ps
`include "ssw_cfg.svh"
module ssw_watchdog
    import ssw_pkg::*;
#(
    parameter ssw_count_type WDOG_CYCLES = `SSW_WDOG_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic clear,
    output logic      expired_q
);
    ssw_count_type cnt_q;

    // Counts while not cleared; expiry sticks until the next clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n || clear) begin
            cnt_q     <= '0;
            expired_q <= 1'b0;
        end else if (cnt_q == WDOG_CYCLES - 32'd1) begin
            expired_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'd1;
        end
    end
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam int RC = 50;
    localparam int WC = 200;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       low_line = 1'b0;
    logic       manual_reset_n = 1'b1;
    logic       pf_in = 1'b0;
    logic [1:0] mode = 2'h0;
    logic       kick, hiz, rst_o_n, rst_o, wdt_n, pf_n;
    int         n_fail = 0;
    int         n_tests = 0;

    always #12.5 ref_clk = ~ref_clk;

    ssw_host_model host (.ref_clk(ref_clk), .mode(mode), .watchdog_kick_in(kick), .watchdog_kick_hiz(hiz));

    ssw_supervisor #(.RESET_CYCLES(RC), .WDOG_CYCLES(WC), .WDOG_ENABLE(1'b1)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .low_line(low_line), .manual_reset_n(manual_reset_n),
        .power_fail_sense_in(pf_in), .watchdog_kick_in(kick), .watchdog_kick_hiz(hiz),
        .reset_out_n_q(rst_o_n), .reset_out_q(rst_o), .watchdog_timeout_n_q(wdt_n),
        .power_fail_flag_n_q(pf_n));

    task automatic check(input string name, input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic final_report();
        if (n_fail == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check_rst(input logic exp);
        check("reset_n", rst_o_n, exp);
        check("reset", rst_o, ~exp);
    endtask

    // Release must land between RC-5 and RC+5 after extra
    task automatic pulse_end(input int extra);
        cyc(extra + RC - 5);
        check_rst(1'b0);
        cyc(10);
        check_rst(1'b1);
    endtask

    task automatic test_low_line();
        @(posedge ref_clk) low_line <= 1'b1;
        cyc(2);
        check("timeout_n", wdt_n, 1'b0);
        cyc(RC + 20);
        check_rst(1'b0);
        @(posedge ref_clk) low_line <= 1'b0;
        cyc(2);
        check("timeout_n", wdt_n, 1'b1);
        pulse_end(-2);
    endtask

    task automatic test_manual();
        @(posedge ref_clk) manual_reset_n <= 1'b0;
        cyc(20);
        @(posedge ref_clk) manual_reset_n <= 1'b1;
        cyc(60);
        check_rst(1'b1);
        @(posedge ref_clk) manual_reset_n <= 1'b0;
        cyc(45);
        check_rst(1'b0);
        cyc(RC + 20);
        check_rst(1'b0);
        @(posedge ref_clk) manual_reset_n <= 1'b1;
        pulse_end(40);
    endtask

    task automatic test_watchdog();
        @(posedge ref_clk) mode <= 2'h1;
        cyc(WC - 60);
        @(posedge ref_clk) low_line <= 1'b1;
        cyc(3);
        @(posedge ref_clk) low_line <= 1'b0;
        cyc(RC + 10);
        cyc(WC - 40);
        check("timeout_n", wdt_n, 1'b1);
        cyc(60);
        check("timeout_n", wdt_n, 1'b0);
        check_rst(1'b1);
        cyc(30);
        check("timeout_n", wdt_n, 1'b0);
        @(posedge ref_clk) mode <= 2'h0;
        cyc(30);
        check("timeout_n", wdt_n, 1'b1);
    endtask

    task automatic test_float();
        @(posedge ref_clk) mode <= 2'h2;
        cyc(WC + 30);
        check("timeout_n", wdt_n, 1'b1);
        @(posedge ref_clk) mode <= 2'h0;
        cyc(25);
    endtask

    task automatic test_power_fail();
        @(posedge ref_clk) pf_in <= 1'b1;
        cyc(2);
        check("pf_flag_n", pf_n, 1'b0);
        @(posedge ref_clk) pf_in <= 1'b0;
        cyc(2);
        check("pf_flag_n", pf_n, 1'b1);
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        pulse_end(0);
        test_low_line();
        test_manual();
        test_watchdog();
        test_float();
        test_power_fail();
        final_report();
    end

    initial begin
        #125000;
        n_fail++;
        final_report();
    end
endmodule
